/* rtl/idpc_pkg.sv */
// idpc_pkg: constants, register map and mode codes of the idle and
// power-down controller.
// assumes: one 40 MHz clock and a 32-bit AHB-Lite register bus.
package idpc_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [11:0] IDPC_PCTL_IDX   = 12'h087; // register index
  localparam logic [11:0] IDPC_PCTL_ADDR  = 12'h21c; // index times four
  localparam logic [11:0] IDPC_STAT_ADDR  = 12'h000; // mode status
  localparam logic [11:0] IDPC_ADDR_MASK  = 12'hffc; // word aligned

  // ---------------------------------------------------------------
  // power control fields and reset value
  // ---------------------------------------------------------------
  localparam int          IDPC_IDLE_POS   = 0;
  localparam int          IDPC_PDWN_POS   = 1;
  localparam int          IDPC_FLG0_POS   = 2;
  localparam int          IDPC_FLG1_POS   = 3;
  localparam logic [3:0]  IDPC_PCTL_RST   = 4'h0;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int          IDPC_CLK_MHZ    = 40;
  localparam int          IDPC_RST_OSC    = 24; // oscillator periods
  localparam int          IDPC_RST_CYC    = IDPC_RST_OSC; // one per clock

  // ---------------------------------------------------------------
  // modes
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    IDPC_RUN   = 2'b00,
    IDPC_IDLE  = 2'b01,
    IDPC_PDOWN = 2'b10,
    IDPC_WAKE  = 2'b11
  } idpc_mode_t;

  // strobe levels in the low power modes
  localparam logic        IDPC_STB_IDLE   = 1'b1;
  localparam logic        IDPC_STB_PDOWN  = 1'b0;

endpackage

/* rtl/idpc_ctrl.sv */
// idpc_ctrl: idle and power-down controller with AHB-Lite registers.
// assumes: the core retires the write that sets a mode bit as its last
// instruction, reports a pending enabled interrupt as a level, and the
// oscillator pad stops when osc_enable is low.
module idpc_ctrl
  import idpc_pkg::*;
(
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // cpu core side
  input  wire logic        irq_pending,
  input  wire logic [1:0]  ext_irq_en,
  output logic             cpu_clk,
  output logic             osc_enable,
  output logic [1:0]       wake_src,
  // external interrupt pins, active low
  input  wire logic        ext_irq_zero_n,
  input  wire logic        ext_irq_one_n,
  // pins during run and low power modes
  input  wire logic        ext_mem,
  input  wire logic        core_ale,
  input  wire logic        core_prog_strobe,
  input  wire logic [7:0]  core_p0_o,
  input  wire logic [7:0]  core_p0_oe,
  input  wire logic [7:0]  core_p2_o,
  input  wire logic [7:0]  port0_latch,
  input  wire logic [7:0]  port2_latch,
  output logic             ale,
  output logic             program_store_strobe,
  output logic      [7:0]  p0_o,
  output logic      [7:0]  p0_oe,
  output logic      [7:0]  p2_o
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  idpc_mode_t  mode;
  idpc_mode_t  next_mode;
  logic        idle_request_bit;
  logic        powerdown_request_bit;
  logic        user_flag_zero;
  logic        user_flag_one;
  logic        dph_wr;
  logic [11:0] dph_addr;
  logic        wr_pctl;
  logic [1:0]  pin_s1;
  logic [1:0]  pin_s2;
  logic [1:0]  low_seen;
  logic [1:0]  wake_low;
  logic [1:0]  released;
  logic        run_en;
  logic        gate_en;
  logic [7:0]  p0_snap;
  logic [7:0]  p2_snap;

  function automatic logic [11:0] word_addr(input logic [31:0] a);
    word_addr = a[11:0] & IDPC_ADDR_MASK;
  endfunction

  // ---------------------------------------------------------------
  // ahb-lite slave, zero wait states, always okay
  // ---------------------------------------------------------------
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign wr_pctl   = dph_wr && (dph_addr == IDPC_PCTL_ADDR);

  // address phase capture and registered read data
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dph_wr   <= 1'b0;
      dph_addr <= 12'h000;
      hrdata   <= 32'h0000_0000;
    end else if (hready) begin
      dph_wr   <= hsel && htrans[1] && hwrite;
      dph_addr <= word_addr(haddr);
      hrdata   <= 32'h0000_0000;
      if (hsel && htrans[1] && !hwrite) begin
        case (word_addr(haddr))
          IDPC_PCTL_ADDR: hrdata <= {28'h000_0000, user_flag_one,
                                     user_flag_zero,
                                     powerdown_request_bit,
                                     idle_request_bit};
          IDPC_STAT_ADDR: hrdata <= {30'h0000_0000, mode};
          default:        hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_s1 <= 2'b11;
      pin_s2 <= 2'b11;
    end else begin
      pin_s1 <= {ext_irq_one_n, ext_irq_zero_n};
      pin_s2 <= pin_s1;
    end
  end

  // only enabled pins take part in waking
  assign wake_low = ~pin_s2 & ext_irq_en;
  assign released = low_seen & pin_s2;

  // ---------------------------------------------------------------
  // power control register
  // ---------------------------------------------------------------
  // reset clears every bit, software writes win over the exit clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {user_flag_one, user_flag_zero, powerdown_request_bit,
       idle_request_bit} <= IDPC_PCTL_RST;
    end else if (wr_pctl) begin
      idle_request_bit      <= hwdata[IDPC_IDLE_POS];
      powerdown_request_bit <= hwdata[IDPC_PDWN_POS];
      user_flag_zero        <= hwdata[IDPC_FLG0_POS];
      user_flag_one         <= hwdata[IDPC_FLG1_POS];
    end else if (mode == IDPC_IDLE && irq_pending) begin
      idle_request_bit      <= 1'b0;
    end else if (mode == IDPC_WAKE && released != 2'b00) begin
      idle_request_bit      <= 1'b0;
      powerdown_request_bit <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // mode sequencer
  // ---------------------------------------------------------------
  always_comb begin
    next_mode = mode;
    case (mode)
      IDPC_RUN: begin
        // the mode-setting write is the last instruction run
        if (wr_pctl && hwdata[IDPC_PDWN_POS]) begin
          next_mode = IDPC_PDOWN;
        end else if (wr_pctl && hwdata[IDPC_IDLE_POS]) begin
          next_mode = IDPC_IDLE;
        end
      end
      IDPC_IDLE: begin
        if (irq_pending) begin
          next_mode = IDPC_RUN;
        end
      end
      IDPC_PDOWN: begin
        if (wake_low != 2'b00) begin
          next_mode = IDPC_WAKE;
        end
      end
      IDPC_WAKE: begin
        // idle is never entered on this exit
        if (released != 2'b00) begin
          next_mode = IDPC_RUN;
        end
      end
      default: next_mode = IDPC_RUN;
    endcase
  end

  // reset is asynchronous so it ends any mode immediately
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode <= IDPC_RUN;
    end else begin
      mode <= next_mode;
    end
  end

  // pins seen low while waking
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      low_seen <= 2'b00;
    end else if (mode == IDPC_WAKE) begin
      low_seen <= low_seen | wake_low;
    end else begin
      low_seen <= wake_low;
    end
  end

  // which pin completed the exit; core picks by priority
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wake_src <= 2'b00;
    end else if (mode == IDPC_WAKE) begin
      wake_src <= released;
    end else begin
      wake_src <= 2'b00;
    end
  end

  // oscillator stops in power-down, restarts on a low enabled pin
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      osc_enable <= 1'b1;
    end else begin
      osc_enable <= (next_mode != IDPC_PDOWN);
    end
  end

  // ---------------------------------------------------------------
  // cpu clock gate
  // ---------------------------------------------------------------
  // no reset pulse reaches the core state, so registers and ram keep
  // their contents; only the clock stops
  assign run_en = (mode == IDPC_RUN);

  // enable changes only while the clock is low
  always_latch begin
    if (!hclk) begin
      gate_en = run_en;
    end
  end

  assign cpu_clk = hclk & gate_en;

  // ---------------------------------------------------------------
  // pin states
  // ---------------------------------------------------------------
  // port snapshot taken as a low power mode begins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      p0_snap <= 8'hff;
      p2_snap <= 8'hff;
    end else if (next_mode == IDPC_RUN) begin
      p0_snap <= port0_latch;
      p2_snap <= ext_mem ? core_p2_o : port2_latch;
    end
  end

  // registered pad drive for each mode
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ale                  <= 1'b1;
      program_store_strobe <= 1'b1;
      p0_o                 <= 8'h00;
      p0_oe                <= 8'h00;
      p2_o                 <= 8'hff;
    end else begin
      case (next_mode)
        IDPC_RUN: begin
          ale                  <= core_ale;
          program_store_strobe <= core_prog_strobe;
          p0_o                 <= core_p0_o;
          p0_oe                <= core_p0_oe;
          p2_o                 <= core_p2_o;
        end
        IDPC_IDLE: begin
          ale                  <= IDPC_STB_IDLE;
          program_store_strobe <= IDPC_STB_IDLE;
          p0_o                 <= 8'h00;
          p0_oe                <= ext_mem ? 8'h00 : ~p0_snap;
          p2_o                 <= p2_snap;
        end
        default: begin
          ale                  <= IDPC_STB_PDOWN;
          program_store_strobe <= IDPC_STB_PDOWN;
          p0_o                 <= 8'h00;
          p0_oe                <= ext_mem ? 8'h00 : ~p0_snap;
          p2_o                 <= port2_latch;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  AST_IDLE_ENTRY: assert property (@(posedge hclk) disable iff (!hresetn)
    (mode == IDPC_RUN && wr_pctl && hwdata[1:0] == 2'b01)
      |=> (mode == IDPC_IDLE && idle_request_bit))
    else $error("idle not entered after write");
  AST_IDLE_GATE: assert property (@(posedge hclk) disable iff (!hresetn)
    (mode == IDPC_IDLE) |-> ##1 (mode != IDPC_IDLE || !gate_en))
    else $error("cpu clock running in idle");
  AST_IDLE_STROBE: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(mode == IDPC_IDLE) |-> (ale && program_store_strobe))
    else $error("strobes not high in idle");
  AST_IDLE_EXIT: assert property (@(posedge hclk) disable iff (!hresetn)
    (mode == IDPC_IDLE && irq_pending && !wr_pctl)
      |=> (mode == IDPC_RUN && !idle_request_bit))
    else $error("interrupt did not end idle");
  AST_PDWN_OSC: assert property (@(posedge hclk) disable iff (!hresetn)
    (mode == IDPC_RUN && wr_pctl && hwdata[1])
      |=> (mode == IDPC_PDOWN && !osc_enable))
    else $error("oscillator not stopped");
  AST_PDWN_WAKE: assert property (@(posedge hclk) disable iff (!hresetn)
    (mode == IDPC_PDOWN && wake_low != 2'b00) |=> osc_enable ##0
      (mode == IDPC_WAKE))
    else $error("low pin did not restart oscillator");
  AST_PDWN_EXIT: assert property (@(posedge hclk) disable iff (!hresetn)
    (mode == IDPC_WAKE && released != 2'b00 && !wr_pctl)
      |=> (mode == IDPC_RUN && !powerdown_request_bit
           && !idle_request_bit && wake_src == $past(released)))
    else $error("power-down exit did not clear both bits");
  AST_PDWN_STROBE: assert property (@(posedge hclk) disable iff (!hresetn)
    (mode == IDPC_PDOWN) |-> (!ale && !program_store_strobe))
    else $error("strobes not low in power-down");
  AST_P0_ZERO: assert property (@(posedge hclk) disable iff (!hresetn)
    (mode != IDPC_RUN) |-> ((p0_oe & ~p0_snap) == p0_oe) && p0_o == 8'h00)
    else $error("port zero drives a one");

endmodule

/* verif/idpc_core_model.sv */
// idpc_core_model: behavioural cpu core and interrupt pin source.
// assumes: the bench moves its commands just after rising hclk edges.
module idpc_core_model (
  // clocks
  input  wire logic       hclk,
  input  wire logic       cpu_clk,
  // bench commands
  input  wire logic       irq_req,
  input  wire logic [1:0] pin_low,
  input  wire logic [1:0] irq_en,
  // towards the controller
  output logic            irq_pending,
  output logic [1:0]      ext_irq_en,
  output logic            ext_irq_zero_n,
  output logic            ext_irq_one_n,
  output logic [7:0]      cnt
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle levels at time zero: pins released high, core at step zero
  initial begin
    irq_pending = 1'b0;
    ext_irq_en = 2'b00;
    ext_irq_zero_n = 1'b1;
    ext_irq_one_n = 1'b1;
    cnt = 8'h00;
  end

  // a waking pin stays low until the bench lets it go
  always @(posedge hclk) begin
    irq_pending <= irq_req;
    ext_irq_en <= irq_en;
    ext_irq_zero_n <= ~pin_low[0];
    ext_irq_one_n <= ~pin_low[1];
  end

  // core activity advances only on the gated clock
  always @(posedge cpu_clk) begin
    cnt <= cnt + 8'h01;
  end
endmodule

/* verif/idle_powerdown_control_tb.sv */
// idle_powerdown_control_tb: bus driven checks of the mode controller.
// assumes: hclk keeps running in power-down; one slave on the bus.
module idle_powerdown_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import idpc_pkg::*;

  // -------------------------------------------------------------
  // signals
  // -------------------------------------------------------------
  localparam logic [11:0] PWR_A = 12'h21c; // control word, 87h * 4
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans, pin_low, irq_en, ext_irq_en, wake_src;
  logic [2:0]  hsize;
  logic        irq_req, irq_pending, cpu_clk, osc_enable, ext_mem;
  logic        irq_zero_n, irq_one_n, ale, program_store_strobe;
  logic [7:0]  cnt, c0, port0_latch, port2_latch, p0_o, p0_oe, p2_o;
  int          n_fail, tests_run;

  idpc_ctrl idpc_ctrl_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .irq_pending(irq_pending), .ext_irq_en(ext_irq_en),
    .cpu_clk(cpu_clk), .osc_enable(osc_enable), .wake_src(wake_src),
    .ext_irq_zero_n(irq_zero_n), .ext_irq_one_n(irq_one_n),
    .ext_mem(ext_mem), .core_ale(cnt[0]), .core_prog_strobe(~cnt[0]),
    .core_p0_o(cnt), .core_p0_oe(8'hff), .core_p2_o(~cnt),
    .port0_latch(port0_latch), .port2_latch(port2_latch), .ale(ale),
    .program_store_strobe(program_store_strobe), .p0_o(p0_o),
    .p0_oe(p0_oe), .p2_o(p2_o));

  idpc_core_model idpc_core_model_inst (
    .hclk(hclk), .cpu_clk(cpu_clk), .irq_req(irq_req),
    .pin_low(pin_low), .irq_en(irq_en), .irq_pending(irq_pending),
    .ext_irq_en(ext_irq_en), .ext_irq_zero_n(irq_zero_n),
    .ext_irq_one_n(irq_one_n), .cnt(cnt));

  // -------------------------------------------------------------
  // tasks
  // -------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask

  // one single word transfer; read data taken at the data phase end
  task automatic bus(input logic wr, input logic [11:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {20'h00000, a};
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] x;
    bus(1'b0, a, 32'h00000000, x);
    chk(x, exp);
  endtask

  // bounded waits on the oscillator request and the wake pulse
  task automatic wait_osc;
    for (int k = 0; k < 20 && osc_enable !== 1'b1; k++) begin
      @(posedge hclk);
      #1;
    end
    chk({31'h0, osc_enable}, 32'h1);
  endtask

  task automatic wait_wake(input logic [1:0] exp);
    for (int k = 0; k < 20 && wake_src === 2'b00; k++) begin
      @(posedge hclk);
      #1;
    end
    chk({30'h0, wake_src}, {30'h0, exp});
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // -------------------------------------------------------------
  // clock, watchdog and sequence
  // -------------------------------------------------------------
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end

  initial begin
    #200000;
    n_fail++;
    end_of_test();
  end

  initial begin
    {hresetn, hsel, hwrite, irq_req, ext_mem} = 5'b00000;
    {haddr, hwdata} = 64'h0;
    {htrans, pin_low, irq_en} = 6'h00;
    hsize = 3'b010;
    port0_latch = 8'h5a;
    port2_latch = 8'h3c;
    n_fail = 0;
    tests_run = 0;
    cyc(20);
    hresetn <= 1'b1;
    #1;
    chk({31'h0, osc_enable}, 32'h1);
    rd(PWR_A, 32'h0);
    rd(IDPC_STAT_ADDR, 32'h0);
    rd(12'h100, 32'h0);
    chk({31'h0, hresp}, 32'h0);
    // idle with both flags set in the same write
    wr(PWR_A, 32'hd);
    cyc(2);
    #1;
    chk({30'h0, ale, program_store_strobe}, 32'h3);
    chk({24'h0, p0_oe}, {24'h0, ~port0_latch});
    chk({24'h0, p0_o & p0_oe}, 32'h0);
    chk({24'h0, p2_o}, 32'h3c);
    c0 = cnt;
    cyc(10);
    #1;
    chk({24'h0, cnt}, {24'h0, c0});
    rd(IDPC_STAT_ADDR, 32'h1);
    rd(PWR_A, 32'hd);
    ext_mem <= 1'b1;
    port2_latch <= 8'hc3;
    cyc(2);
    #1;
    chk({24'h0, p0_oe}, 32'h0);
    chk({24'h0, p2_o}, 32'h3c);
    @(posedge hclk);
    ext_mem <= 1'b0;
    irq_req <= 1'b1;
    cyc(4);
    irq_req <= 1'b0;
    rd(PWR_A, 32'hc);
    #1;
    c0 = cnt;
    cyc(5);
    #1;
    chk({24'h0, cnt - c0}, 32'h5);
    // power-down, woken only by the enabled pin one
    irq_en <= 2'b10;
    wr(PWR_A, 32'h6);
    cyc(2);
    #1;
    chk({30'h0, osc_enable, ale}, 32'h0);
    chk({31'h0, program_store_strobe}, 32'h0);
    chk({24'h0, p2_o}, 32'hc3);
    chk({24'h0, p0_oe}, {24'h0, ~port0_latch});
    @(posedge hclk);
    pin_low <= 2'b01;
    irq_req <= 1'b1;
    cyc(10);
    #1;
    chk({31'h0, osc_enable}, 32'h0);
    rd(IDPC_STAT_ADDR, 32'h2);
    pin_low <= 2'b10;
    irq_req <= 1'b0;
    wait_osc();
    rd(IDPC_STAT_ADDR, 32'h3);
    pin_low <= 2'b00;
    wait_wake(2'b10);
    rd(PWR_A, 32'h4);
    rd(IDPC_STAT_ADDR, 32'h0);
    // both bits, both pins; the first release ends the mode
    irq_en <= 2'b11;
    wr(PWR_A, 32'h3);
    cyc(2);
    pin_low <= 2'b11;
    wait_osc();
    pin_low <= 2'b10;
    wait_wake(2'b01);
    rd(PWR_A, 32'h0);
    rd(IDPC_STAT_ADDR, 32'h0);
    pin_low <= 2'b00;
    // a short reset ends idle and power-down alike
    for (int i = 0; i < 2; i++) begin
      wr(PWR_A, i == 0 ? 32'h9 : 32'h6);
      cyc(3);
      hresetn <= 1'b0;
      cyc(24);
      hresetn <= 1'b1;
      rd(PWR_A, 32'h0);
      rd(IDPC_STAT_ADDR, 32'h0);
    end
    end_of_test();
  end
endmodule
